// ---- dv/dfp_core_properties.sv ----
// concurrent checks on the ports of the fault protection core.
// assumes one clock domain and an async active-high reset.
`include "dfp_consts.svh"
`default_nettype none

module dfp_chk #(
  parameter int unsigned DEGLITCH_NS = `DFP_T_OC_NS  // deglitch of the core
) (
  input wire logic                 clk_sys_in,
  input wire logic                 rst_in,
  input wire dfp_pkg::dfp_wb_req_t wb_req_in,
  input wire logic                 wb_ack_out,
  input wire logic [31:0]          wb_dat_out,
  input wire logic                 vdd_low_in,
  input wire logic                 sleep_in_n,
  input wire dfp_pkg::dfp_vec_t    ilim_hs_in,
  input wire dfp_pkg::dfp_vec_t    ilim_ls_in,
  input wire dfp_pkg::dfp_vec_t    gate_hs_out,
  input wire dfp_pkg::dfp_vec_t    gate_ls_out,
  input wire logic                 charge_pump_out,
  input wire logic                 fault_n_out,
  input wire logic                 fault_n_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DG = DEGLITCH_NS / `DFP_CLK_NS;  // deglitch in cycles
  int run;  // cycles in a row with some limiter on

  // ==========================================================================
  // helper: saturating length of the present limiter run
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      run <= 0;
    end else if (|{ilim_hs_in, ilim_ls_in}) begin
      run <= (run < 4096) ? run + 1 : run;
    end else begin
      run <= 0;
    end
  end

  default clocking d_cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  // ==========================================================================
  // protection
  a_shdn_bridges_off: assert property ((vdd_low_in || !sleep_in_n) |=>
    (gate_hs_out == '0 && gate_ls_out == '0 && !charge_pump_out)) else $error("shutdown left a drive on");
  a_pump_runs: assert property ((!vdd_low_in && sleep_in_n) |=> charge_pump_out)
    else $error("charge pump off while supplied");
  a_limit_withdraws: assert property (|{ilim_hs_in, ilim_ls_in} |=>
    ((gate_hs_out & $past(ilim_hs_in)) == '0 && (gate_ls_out & $past(ilim_ls_in)) == '0))
    else $error("limiter did not withdraw gate");
  // a short run must never trip: the counter restarts on every gap
  a_trip_deglitch: assert property ((run > 0 && run < DG - 1) |-> !$rose(fault_n_oe_out))
    else $error("trip before deglitch time");
  a_fault_held: assert property ($fell(fault_n_oe_out) |->
    ($past(wb_ack_out && wb_req_in.we) || $past(wb_ack_out && wb_req_in.we, 2)))
    else $error("fault released without a write");
  a_pin_open_drain: assert property (!fault_n_out) else $error("fault pin drives high");

  // ==========================================================================
  // register bus
  a_ack_answers: assert property ((wb_req_in.cyc && wb_req_in.stb && !wb_ack_out) |=> wb_ack_out)
    else $error("request not acked");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack longer than a cycle");
  a_dat_idle: assert property (!wb_ack_out |-> wb_dat_out == '0) else $error("read data outside ack");

  c_trip: cover property ($rose(fault_n_oe_out));
  c_wake: cover property (!sleep_in_n ##1 sleep_in_n);
  c_write: cover property (wb_ack_out && wb_req_in.we);
endmodule : dfp_chk

bind dfp_core dfp_chk #(.DEGLITCH_NS(DEGLITCH_NS)) i_chk (
  .clk_sys_in(clk_sys_in), .rst_in(rst_in), .wb_req_in(wb_req_in), .wb_ack_out(wb_ack_out),
  .wb_dat_out(wb_dat_out), .vdd_low_in(vdd_low_in), .sleep_in_n(sleep_in_n),
  .ilim_hs_in(ilim_hs_in), .ilim_ls_in(ilim_ls_in), .gate_hs_out(gate_hs_out),
  .gate_ls_out(gate_ls_out), .charge_pump_out(charge_pump_out), .fault_n_out(fault_n_out),
  .fault_n_oe_out(fault_n_oe_out));

`default_nettype wire

// ---- dv/dfp_core_tb.sv ----
// self-checking bench of the fault protection core.
// assumes the host model resolves the fault pin; short deglitch for speed.
`include "dfp_consts.svh"
`default_nettype none

module dfp_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned DGNS = 250;         // shortened deglitch
  localparam int DG = DGNS / `DFP_CLK_NS;     // deglitch in cycles
  logic                 clk, rst, ack, vdd_low, slp_n, cp, fin, fo, foe;
  dfp_pkg::dfp_wb_req_t req;                  // bus request
  logic [31:0]          dat, rd;              // read data, last read
  dfp_pkg::dfp_vec_t    ilh, ill, gh, gl, tf; // limiters and drives
  int                   err_total, n_compared, cyc_cnt;

  dfp_core #(.DEGLITCH_NS(DGNS)) i_dut (
    .clk_sys_in(clk), .rst_in(rst), .wb_req_in(req), .wb_ack_out(ack), .wb_dat_out(dat),
    .vdd_low_in(vdd_low), .sleep_in_n(slp_n), .ilim_hs_in(ilh), .ilim_ls_in(ill),
    .gate_hs_out(gh), .gate_ls_out(gl), .turnoff_fast_out(tf), .charge_pump_out(cp),
    .fault_n_in(fin), .fault_n_out(fo), .fault_n_oe_out(foe));
  dfp_host_model i_host (.fault_oe_in(foe), .fault_level_out(fin));

  // ==========================================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // classic cycle: hold until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED t=%0t no ack", $time);
    end
    rd = dat;
    req <= '0;
  endtask : wb

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdc

  task give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // ==========================================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    rst = 1'b1; req = '0; vdd_low = 1'b0; slp_n = 1'b1; ilh = '0; ill = '0;
    err_total = 0; n_compared = 0; cyc_cnt = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h00, 32'h4);
    rdc(8'h0C, 32'h0);
    rdc(8'h20, 32'h0);
    wb(1'b1, 8'h14, 32'hFFF);
    wb(1'b1, 8'h10, 32'h1);
    rdc(8'h00, 32'h5);
    // sleep then supply loss; a clear while down must not restore the flag
    for (int k = 0; k < 2; k++) begin
      if (k == 0) slp_n <= 1'b0; else vdd_low <= 1'b1;
      repeat (3) @(posedge clk);
      chk(32'(gh), 32'h0);
      chk(32'(cp), 32'h0);
      wb(1'b1, 8'h10, 32'h1);
      rdc(8'h00, 32'hC);
      slp_n <= 1'b1;
      vdd_low <= 1'b0;
      repeat (3) @(posedge clk);
      chk(32'(cp), 32'h1);
      chk(32'(gh), 32'hFFF);
      rdc(8'h00, 32'h4);
      wb(1'b1, 8'h10, 32'h1);
      rdc(8'h00, 32'h5);
    end
    // trips: m=0 unmasked fast, m=1 masked at bridge slew
    // bridge 5 set to its fast slew so the bridge-slew code is seen both ways
    wb(1'b1, 8'h1C, 32'h20);
    for (int m = 0; m < 2; m++) begin
      wb(1'b1, 8'h0C, 32'((m << 1) | m));
      @(posedge clk) ilh[3 + m] <= 1'b1;
      repeat (DG - 5) @(posedge clk);
      ilh[3 + m] <= 1'b0;
      @(posedge clk) ilh[3 + m] <= 1'b1;
      repeat (DG - 3) @(posedge clk);
      chk(32'(foe), 32'h0);
      repeat (8) @(posedge clk);
      chk(32'(foe), 32'(m == 0));
      chk(32'(tf[3 + m]), 32'(m == 0));
      chk(32'(tf[5]), 32'h1);
      chk(32'(cp), 32'h1);
      ilh[3 + m] <= 1'b0;
      rdc(8'h04, 32'h1 << (3 + m));
      rdc(8'h08, 32'h0);
      rdc(8'h00, m ? 32'h7 : 32'h3);
      chk(32'(gh[3 + m]), 32'h0);
      wb(1'b1, 8'h10, 32'h1);
      repeat (3) @(posedge clk);
      chk(32'(foe), 32'h0);
      chk(32'(gh[3 + m]), 32'h1);
      rdc(8'h04, 32'h0);
    end
    // full-bridge short: high side of bridge 1 limits first
    wb(1'b1, 8'h0C, 32'h0);
    wb(1'b1, 8'h14, 32'h2);
    wb(1'b1, 8'h18, 32'h4);
    @(posedge clk) ilh[1] <= 1'b1;
    repeat (10) @(posedge clk);
    ill[2] <= 1'b1;
    repeat (DG - 6) @(posedge clk);
    ilh[1] <= 1'b0;
    ill[2] <= 1'b0;
    rdc(8'h04, 32'h2);
    rdc(8'h08, 32'h0);
    chk(32'(gh), 32'h0);
    chk(32'(gl), 32'h4);
    wb(1'b1, 8'h10, 32'h1);
    rdc(8'h04, 32'h0);
    chk(32'(gh), 32'h2);
    give_verdict();
  end
endmodule : dfp_core_tb

`default_nettype wire

// ---- dv/dfp_host_model.sv ----
// host side model: resolves the open-drain fault pin as the board does.
// assumes the core raises its enable while it pulls the pin low.
`default_nettype none

module dfp_host_model (
  input  wire logic fault_oe_in,     // core pulls the pin low
  output logic      fault_level_out  // level seen on the wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // pull-up: a released pin reads high, so no stale low is ever seen
  assign fault_level_out = fault_oe_in ? 1'b0 : 1'b1;
endmodule : dfp_host_model

`default_nettype wire

// ---- include/dfp_consts.svh ----
// constants of the driver fault protection block: offsets, bit positions,
// reset values and timing figures.
// assumes it is included by bare name; holds definitions only.
`ifndef DFP_CONSTS_SVH
`define DFP_CONSTS_SVH

// ==========================================================================
// sizes
`define DFP_NB          12
`define DFP_DG_CW       16
`define DFP_ADR_W       8
`define DFP_DAT_W       32

// ==========================================================================
// timing
`define DFP_CLK_NS      5
`define DFP_T_OC_NS     10000

// ==========================================================================
// register byte offsets
`define DFP_OFS_CHIP_STAT 8'h00
`define DFP_OFS_OC_HS     8'h04
`define DFP_OFS_OC_LS     8'h08
`define DFP_OFS_CONFIG    8'h0C
`define DFP_OFS_CMD       8'h10
`define DFP_OFS_EN_HS     8'h14
`define DFP_OFS_EN_LS     8'h18
`define DFP_OFS_SLEW      8'h1C

// ==========================================================================
// field positions
`define DFP_BIT_PGOOD   0
`define DFP_BIT_OCSUM   1
`define DFP_BIT_PIN     2
`define DFP_BIT_SHDN    3
`define DFP_BIT_MASK    0
`define DFP_SEL_LO      1
`define DFP_SEL_HI      2
`define DFP_BIT_CLR     0

// ==========================================================================
// encodings and reset values
`define DFP_SLEW_FAST   2'h0
`define DFP_SLEW_BRIDGE 2'h1
`define DFP_RST_MASK    1'h0
`define DFP_RST_SLEW    2'h0
`define DFP_RST_PGOOD   1'h0

`endif

// ---- include/dfp_pkg.sv ----
// types of the driver fault protection block.
// assumes dfp_consts.svh is reachable on the include path.
`include "dfp_consts.svh"
`default_nettype none

package dfp_pkg;

  // ========================================================================
  // bus carrier
  typedef struct packed {
    logic                  cyc;  // bus cycle
    logic                  stb;  // strobe
    logic                  we;   // write enable
    logic [`DFP_ADR_W-1:0] adr;  // byte address
    logic [3:0]            sel;  // byte lanes
    logic [`DFP_DAT_W-1:0] dat;  // write data
  } dfp_wb_req_t;

  typedef logic [`DFP_NB-1:0] dfp_vec_t;

  // ========================================================================
  // registered state of the core, apart from the deglitch counters
  typedef struct packed {
    logic                  pgood;      // power_good_flag
    logic                  oc_sum;     // overcurrent_flag summary
    dfp_vec_t              oc_hs;      // hs_overcurrent_bit per bridge
    dfp_vec_t              oc_ls;      // ls_overcurrent_bit per bridge
    dfp_vec_t              br_off;     // bridge tripped, held hi-z
    logic                  mask;       // overcurrent_report_mask
    logic [1:0]            slew_sel;   // shutoff_slew_select
    dfp_vec_t              en_hs;      // high side enables
    dfp_vec_t              en_ls;      // low side enables
    dfp_vec_t              sr;         // bridge_slew_setting, 1 = fast
    dfp_vec_t              gate_hs;    // high side gate drive
    dfp_vec_t              gate_ls;    // low side gate drive
    dfp_vec_t              off_fast;   // turn-off slew of a trip
    logic                  fault_drv;  // pulling fault pin low
    logic                  cp_en;      // charge pump enable
    logic                  ack;        // bus acknowledge
    logic [`DFP_DAT_W-1:0] rdat;       // bus read data
  } dfp_state_t;

  // ========================================================================
  // state of one deglitch counter
  typedef struct packed {
    logic [`DFP_DG_CW-1:0] cnt;   // cycles the limiter has been active
    logic                  trip;  // deglitch time elapsed
  } dfp_dg_state_t;

endpackage : dfp_pkg

`default_nettype wire

// ---- src/dfp_core.sv ----
// fault protection core of a multi half-bridge driver with a wishbone
// register slave.
// assumes all inputs are synchronous to clk_sys_in and that the fault pin
// is an open-drain net pulled up on the board.
//
// Design decisions made here: the Wishbone register port and the placing of the registers.
`include "dfp_consts.svh"
`default_nettype none

module dfp_core #(
  parameter int unsigned DEGLITCH_NS = `DFP_T_OC_NS  // overcurrent deglitch in ns
) (
  input  wire logic                      clk_sys_in,       // system clock, 200 MHz
  input  wire logic                      rst_in,           // async reset, active high
  input  wire dfp_pkg::dfp_wb_req_t      wb_req_in,        // wishbone request
  output logic                           wb_ack_out,       // wishbone acknowledge
  output logic [`DFP_DAT_W-1:0]          wb_dat_out,       // wishbone read data
  input  wire logic                      vdd_low_in,       // logic supply below reset level
  input  wire logic                      sleep_in_n,       // sleep request, active low
  input  wire dfp_pkg::dfp_vec_t         ilim_hs_in,       // high side limiter active
  input  wire dfp_pkg::dfp_vec_t         ilim_ls_in,       // low side limiter active
  output dfp_pkg::dfp_vec_t              gate_hs_out,      // high side gate drive
  output dfp_pkg::dfp_vec_t              gate_ls_out,      // low side gate drive
  output dfp_pkg::dfp_vec_t              turnoff_fast_out, // 1 = fast turn-off slew
  output logic                           charge_pump_out,  // charge pump enable
  input  wire logic                      fault_n_in,       // fault pin level
  output logic                           fault_n_out,      // fault pin drive value
  output logic                           fault_n_oe_out    // fault pin pulled low
);

  // ========================================================================
  // derived timing
  // a least time: round up, never below one cycle
  localparam int unsigned DG_RAW    = (DEGLITCH_NS + `DFP_CLK_NS - 1) / `DFP_CLK_NS;
  localparam int unsigned DG_CYCLES = (DG_RAW < 1) ? 1 : DG_RAW;
  localparam int          NB        = `DFP_NB;  // number of half-bridges

  dfp_pkg::dfp_state_t st;       // registered state
  dfp_pkg::dfp_state_t next_st;  // next state

  dfp_pkg::dfp_vec_t trip_hs;    // high side deglitch elapsed
  dfp_pkg::dfp_vec_t trip_ls;    // low side deglitch elapsed

  // ========================================================================
  // deglitch counters, one per transistor
  // a tripped bridge holds its counters at zero so it cannot retrip
  // while already off
  for (genvar i = 0; i < NB; i++) begin : g_dg
    dfp_deglitch #(
      .LIMIT_CYCLES (DG_CYCLES)
    ) u_dg_hs (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .limit_in   (ilim_hs_in[i]),
      .restart_in (st.br_off[i]),
      .trip_out   (trip_hs[i])
    );
    dfp_deglitch #(
      .LIMIT_CYCLES (DG_CYCLES)
    ) u_dg_ls (
      .clk_sys_in (clk_sys_in),
      .rst_in     (rst_in),
      .limit_in   (ilim_ls_in[i]),
      .restart_in (st.br_off[i]),
      .trip_out   (trip_ls[i])
    );
  end

  // ========================================================================
  // byte-lane merge of a register write
  function automatic logic [`DFP_DAT_W-1:0] merge(
    input logic [`DFP_DAT_W-1:0] old_v,
    input logic [`DFP_DAT_W-1:0] new_v,
    input logic [3:0]            sel
  );
    logic [`DFP_DAT_W-1:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // ========================================================================
  // next state
  always_comb begin
    logic                  shdn;     // supply or sleep shutdown
    logic                  req;      // request on the bus
    logic                  commit;   // write takes effect this edge
    logic                  clr;      // fault_clear_cmd written
    logic                  taken;    // a trip already won this cycle
    logic [`DFP_DAT_W-1:0] wval;     // merged write value
    logic [`DFP_DAT_W-1:0] rval;     // read value
    shdn   = 1'b0;
    req    = 1'b0;
    commit = 1'b0;
    clr    = 1'b0;
    taken  = 1'b0;
    wval   = '0;
    rval   = '0;
    next_st = st;

    // supply loss or sleep low shuts all gates and the charge pump; level follows the
    // pins, so the driver resumes by itself
    shdn = vdd_low_in | ~sleep_in_n;

    // ---- bus handshake: ack one cycle after the request, dropped next
    req         = wb_req_in.cyc & wb_req_in.stb;
    commit      = req & wb_req_in.we & st.ack;
    next_st.ack = req & ~st.ack;

    // ---- read mux, latched together with the ack
    case (wb_req_in.adr)
      `DFP_OFS_CHIP_STAT: begin
        rval[`DFP_BIT_PGOOD] = st.pgood;
        rval[`DFP_BIT_OCSUM] = st.oc_sum;
        rval[`DFP_BIT_PIN]   = fault_n_in;
        rval[`DFP_BIT_SHDN]  = ~st.cp_en;
      end
      `DFP_OFS_OC_HS: begin
        rval[NB-1:0] = st.oc_hs;
      end
      `DFP_OFS_OC_LS: begin
        rval[NB-1:0] = st.oc_ls;
      end
      `DFP_OFS_CONFIG: begin
        rval[`DFP_BIT_MASK]               = st.mask;
        rval[`DFP_SEL_HI:`DFP_SEL_LO]     = st.slew_sel;
      end
      `DFP_OFS_EN_HS: begin
        rval[NB-1:0] = st.en_hs;
      end
      `DFP_OFS_EN_LS: begin
        rval[NB-1:0] = st.en_ls;
      end
      `DFP_OFS_SLEW: begin
        rval[NB-1:0] = st.sr;
      end
      default: begin
        rval = '0;  // unmapped and command word read as zero
      end
    endcase
    next_st.rdat = (req & ~st.ack & ~wb_req_in.we) ? rval : '0;

    // ---- register writes at the edge the master sees ack
    if (commit) begin
      case (wb_req_in.adr)
        `DFP_OFS_CONFIG: begin
          wval = merge({29'h0, st.slew_sel, st.mask}, wb_req_in.dat, wb_req_in.sel);
          next_st.mask     = wval[`DFP_BIT_MASK];
          next_st.slew_sel = wval[`DFP_SEL_HI:`DFP_SEL_LO];
        end
        `DFP_OFS_CMD: begin
          clr = wb_req_in.sel[0] & wb_req_in.dat[`DFP_BIT_CLR];
        end
        `DFP_OFS_EN_HS: begin
          wval = merge({20'h0, st.en_hs}, wb_req_in.dat, wb_req_in.sel);
          next_st.en_hs = wval[NB-1:0];
        end
        `DFP_OFS_EN_LS: begin
          wval = merge({20'h0, st.en_ls}, wb_req_in.dat, wb_req_in.sel);
          next_st.en_ls = wval[NB-1:0];
        end
        `DFP_OFS_SLEW: begin
          wval = merge({20'h0, st.sr}, wb_req_in.dat, wb_req_in.sel);
          next_st.sr = wval[NB-1:0];
        end
        default: begin
          wval = '0;  // status words and holes ignore writes
        end
      endcase
    end

    // ---- power-good flag
    // held low for as long as the supply is out or sleep is low, so the
    // flag is found low after recovery; only the clear brings it back
    if (shdn) begin
      next_st.pgood = 1'b0;
    end else if (clr) begin
      next_st.pgood = 1'b1;
    end

    // ---- overcurrent flags: clear first, so a trip in the same cycle wins
    if (clr) begin
      next_st.oc_sum = 1'b0;
      next_st.oc_hs  = '0;
      next_st.oc_ls  = '0;
      next_st.br_off = '0;
    end

    // ---- new trips; lowest transistor wins when several land together,
    // the partner of a shorted full bridge loses its current once the
    // winner goes hi-z and its counter restarts
    for (int i = 0; i < NB; i++) begin
      if (!taken && !st.br_off[i] && trip_hs[i]) begin
        taken              = 1'b1;
        next_st.br_off[i]  = 1'b1;  // whole bridge hi-z
        next_st.oc_hs[i]   = 1'b1;
        next_st.oc_sum     = 1'b1;
      end
      if (!taken && !st.br_off[i] && trip_ls[i]) begin
        taken              = 1'b1;
        next_st.br_off[i]  = 1'b1;
        next_st.oc_ls[i]   = 1'b1;
        next_st.oc_sum     = 1'b1;
      end
    end

    // ---- gate drive: limiter pulls its own gate, trip pulls both,
    // shutdown pulls all
    next_st.gate_hs = st.en_hs & ~ilim_hs_in & ~next_st.br_off & {NB{~shdn}};
    next_st.gate_ls = st.en_ls & ~ilim_ls_in & ~next_st.br_off & {NB{~shdn}};

    // ---- turn-off slew used by a tripped bridge
    // codes 10b and 11b behave like the default fast turn-off
    for (int i = 0; i < NB; i++) begin
      if (st.slew_sel == `DFP_SLEW_BRIDGE) begin
        next_st.off_fast[i] = st.sr[i];
      end else begin
        next_st.off_fast[i] = 1'b1;
      end
    end

    // charge pump ignores overcurrent, only shutdown stops it
    next_st.cp_en = ~shdn;

    // ---- fault pin: low while a flag is pending and not masked;
    // released otherwise
    next_st.fault_drv = next_st.oc_sum & ~st.mask;
  end

  // ========================================================================
  // state register
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st          <= '0;
      st.pgood    <= `DFP_RST_PGOOD;
      st.mask     <= `DFP_RST_MASK;
      st.slew_sel <= `DFP_RST_SLEW;
      st.off_fast <= '1;
    end else begin
      st <= next_st;
    end
  end

  // ========================================================================
  // outputs
  // open-drain: the value is always low, only the enable moves; the
  // high level comes from the board pull-up
  assign wb_ack_out       = st.ack;
  assign wb_dat_out       = st.rdat;
  assign gate_hs_out      = st.gate_hs;
  assign gate_ls_out      = st.gate_ls;
  assign turnoff_fast_out = st.off_fast;
  assign charge_pump_out  = st.cp_en;
  assign fault_n_out      = 1'b0;
  assign fault_n_oe_out   = st.fault_drv;

endmodule : dfp_core

`default_nettype wire

// ---- src/dfp_deglitch.sv ----
// overcurrent deglitch for one transistor.
// assumes limit_in is synchronous to clk_sys_in.
`include "dfp_consts.svh"
`default_nettype none

module dfp_deglitch #(
  parameter int unsigned LIMIT_CYCLES = 1  // cycles the limiter must stay on
) (
  input  wire logic clk_sys_in,  // system clock
  input  wire logic rst_in,      // async reset, active high
  input  wire logic limit_in,    // current limiter active
  input  wire logic restart_in,  // force the count back to zero
  output logic      trip_out     // limiter held past the deglitch time
);

  // last count value before the trip; counter width from the header
  localparam logic [`DFP_DG_CW-1:0] LAST = `DFP_DG_CW'(LIMIT_CYCLES - 1);

  dfp_pkg::dfp_dg_state_t st;       // registered state
  dfp_pkg::dfp_dg_state_t next_st;  // next state

  // ========================================================================
  // counting
  // count restarts on any gap so short spikes never add up
  always_comb begin
    next_st = st;
    if (restart_in || !limit_in) begin
      next_st.cnt  = '0;
      next_st.trip = 1'b0;
    end else if (st.cnt == LAST) begin
      next_st.trip = 1'b1;  // held the full time
    end else begin
      next_st.cnt = st.cnt + `DFP_DG_CW'(1);
    end
  end

  // ========================================================================
  // state register
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign trip_out = st.trip;

endmodule : dfp_deglitch

`default_nettype wire
